// *** hdl/thermal_pkg.sv ***
// Constants, register map and carrier types of the thermal overload stage.
// Function
// - Phase RMS from harmonics one to fifteen.
// - Model fed by largest phase current.
// - Exponential heating, time constant 2-180 minutes.
// - Trip level is k times ambient factor.
// - Trip when temperature rise reaches 100%.
// - Ambient factor from temperature and limits.
// - Ambient factor unity in three cases.
// - Cooling coefficient stretches constant below 0.3.
// - Rise state is memory; preload from it.
// - Rise starts at seventy percent after reset.
// - Start signal at settable alarm limit.
// - Start and trip release at 95% of their pickup level.
// - One fixed parameter set only.
package thermal_pkg;
	// Model step period and its cycle count at the 50 MHz clock.
	localparam int CLK_NS        = 20;
	localparam int UPDATE_MS     = 100;
	localparam int UPDATE_CYC    = UPDATE_MS * 1000000 / CLK_NS;
	localparam int STEPS_PER_MIN = 60000 / UPDATE_MS;
	// Scaling constants.
	localparam int PCT        = 100;
	localparam int COOL_SCALE = 10;
	localparam int SF_SCALE   = 100;
	localparam int Q12_ONE    = 4096;
	localparam int AMB_REF    = 40;
	localparam int AMB_HOT    = 70;
	localparam int REL_PCT    = 95;
	localparam logic [3:0]  HARM_MAX   = 4'hf;
	localparam logic [35:0] THETA_ONE  = 36'h100000000;
	localparam logic [35:0] THETA_INIT = 36'h0b3333333;
	localparam logic [35:0] THETA_REL  = 36'h0f3333333;
	localparam logic [31:0] COOL_I2    = 32'h00170a3d;
	localparam logic [15:0] KT_ONE     = 16'h1000;
	// Register word offsets.
	localparam logic [3:0] A_SERVICE = 4'h0;
	localparam logic [3:0] A_TAU     = 4'h1;
	localparam logic [3:0] A_COOL    = 4'h2;
	localparam logic [3:0] A_LIM40   = 4'h3;
	localparam logic [3:0] A_LIM70   = 4'h4;
	localparam logic [3:0] A_AMBIENT = 4'h5;
	localparam logic [3:0] A_ALARM   = 4'h6;
	localparam logic [3:0] A_STATUS  = 4'h7;
	localparam logic [3:0] A_THETA   = 4'h8;
	localparam logic [3:0] A_PRELOAD = 4'h9;
	localparam logic [3:0] A_TRIPLVL = 4'ha;
	localparam logic [3:0] A_KTHETA  = 4'hb;
	// Field positions.
	localparam int B_SENSOR = 8;
	localparam int B_START  = 0;
	localparam int B_TRIP   = 1;
	localparam int B_BUSY   = 2;
	// Reset values and legal ranges of the settings.
	localparam logic [7:0] SF_RST = 8'h64, SF_MIN = 8'h0a, SF_MAX = 8'hf0;
	localparam logic [7:0] TAU_RST = 8'h1e, TAU_MIN = 8'h02, TAU_MAX = 8'hb4;
	localparam logic [7:0] COOL_RST = 8'h0a, COOL_MIN = 8'h0a, COOL_MAX = 8'h64;
	localparam logic [7:0] L40_RST = 8'h64, L40_MIN = 8'h46, L40_MAX = 8'h78;
	localparam logic [7:0] L70_RST = 8'h64, L70_MIN = 8'h32, L70_MAX = 8'h64;
	localparam logic [7:0] AL_RST = 8'h5a, AL_MIN = 8'h3c, AL_MAX = 8'h63;
	localparam logic [7:0] AMB_RST = 8'h28, AMB_MIN = 8'hc9, AMB_MAX = 8'h7d;

	typedef enum logic [1:0] {ST_IDLE, ST_TARGET, ST_STEP, ST_SQRT} upd_state_t;

	// One harmonic magnitude of one phase, Q4.12 per unit of rated current.
	typedef struct packed {
		logic        valid;
		logic        last;
		logic [1:0]  phase;
		logic [3:0]  order;
		logic [15:0] amp;
	} harm_sample_t;

	// Register port request.
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;
endpackage : thermal_pkg

// *** hdl/thermal_overload_model.sv ***
// Thermal overload stage: RMS gathering, thermal model, start and trip outputs.
module thermal_overload_model
	import thermal_pkg::*;
#(
	parameter int UPDATE_CYCLES = UPDATE_CYC
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	input  wire harm_sample_t harm,
	input  wire reg_req_t     req,
	output logic [15:0]       rd_data,
	output logic              stage_start,
	output logic              stage_trip
);

	function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
		clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp8

	function automatic logic [31:0] sat32(input logic [35:0] v);
		sat32 = (|v[35:32]) ? 32'hffffffff : v[31:0];
	endfunction : sat32

	logic [7:0]  sf_r, tau_r, cool_r, lim40_r, lim70_r, alarm_r, amb_r;
	logic        sensor_r;
	logic [15:0] rd_data_r;
	logic        start_r, trip_r;
	logic [31:0] ph_i2 [3];
	logic [31:0] sq;
	logic        frame_r;
	logic [31:0] i2max_r;
	logic [31:0] tick_cnt_r;
	logic        tick_r;
	logic [15:0] kt_r, kt_nxt, trip_current_level_r;
	logic [31:0] imax2_r;
	logic [35:0] al_th_r, al_rel_r;
	upd_state_t  state_r;
	logic [5:0]  div_cnt_r;
	logic [63:0] div_num_r;
	logic [31:0] div_den_r, div_rem_r;
	logic [32:0] rem_sh;
	logic        qbit;
	logic [63:0] q_full;
	logic [35:0] theta_r, target_r, target_nxt, mag;
	logic        sign_r;
	logic        cool_w;
	logic [31:0] n_w;
	logic [17:0] root_r, trial;
	logic [4:0]  idx_r;
	logic [15:0] preload_r;

	// single setting set.
	// Settings are clamped on write so the model never sees an illegal value.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sf_r     <= SF_RST;
			tau_r    <= TAU_RST;
			cool_r   <= COOL_RST;
			lim40_r  <= L40_RST;
			lim70_r  <= L70_RST;
			alarm_r  <= AL_RST;
			amb_r    <= AMB_RST;
			sensor_r <= 1'b0;
		end else if (ce && req.wr) begin
			case (req.addr)
				A_SERVICE: sf_r <= clamp8(req.wdata[7:0], SF_MIN, SF_MAX);
				A_TAU:     tau_r <= clamp8(req.wdata[7:0], TAU_MIN, TAU_MAX);
				A_COOL:    cool_r <= clamp8(req.wdata[7:0], COOL_MIN, COOL_MAX);
				A_LIM40:   lim40_r <= clamp8(req.wdata[7:0], L40_MIN, L40_MAX);
				A_LIM70:   lim70_r <= clamp8(req.wdata[7:0], L70_MIN, L70_MAX);
				A_ALARM:   alarm_r <= clamp8(req.wdata[7:0], AL_MIN, AL_MAX);
				A_AMBIENT: begin
					sensor_r <= req.wdata[B_SENSOR];
					if ($signed(req.wdata[7:0]) < $signed(AMB_MIN))
						amb_r <= AMB_MIN;
					else if ($signed(req.wdata[7:0]) > $signed(AMB_MAX))
						amb_r <= AMB_MAX;
					else
						amb_r <= req.wdata[7:0];
				end
				default: ;
			endcase
		end
	end

	// Read data stand for exactly the cycle after the strobe; unmapped words read zero.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rd_data_r <= 16'h0000;
		end else if (ce) begin
			rd_data_r <= 16'h0000;
			if (req.rd) begin
				case (req.addr)
					A_SERVICE: rd_data_r <= {8'h00, sf_r};
					A_TAU:     rd_data_r <= {8'h00, tau_r};
					A_COOL:    rd_data_r <= {8'h00, cool_r};
					A_LIM40:   rd_data_r <= {8'h00, lim40_r};
					A_LIM70:   rd_data_r <= {8'h00, lim70_r};
					A_ALARM:   rd_data_r <= {8'h00, alarm_r};
					A_AMBIENT: rd_data_r <= {7'h00, sensor_r, amb_r};
					A_STATUS:  rd_data_r <= {13'h0000, state_r != ST_IDLE, trip_r, start_r};
					A_THETA:   rd_data_r <= theta_r[35:20];
					A_PRELOAD: rd_data_r <= preload_r;
					A_TRIPLVL: rd_data_r <= trip_current_level_r;
					A_KTHETA:  rd_data_r <= kt_r;
					default:   rd_data_r <= 16'h0000;
				endcase
			end
		end
	end

	assign sq = 32'(harm.amp) * 32'(harm.amp);

	// harmonic power sum.
	// Squared harmonic magnitudes add to the squared RMS, so no root is needed here.
	for (genvar p = 0; p < 3; p++) begin : g_phase
		logic [35:0] acc_r, acc_nxt;
		logic [31:0] i2_r;
		always_comb begin
			acc_nxt = acc_r;
			if (harm.phase == 2'(p) && harm.order != 4'h0 && harm.order <= HARM_MAX)
				acc_nxt = acc_r + {4'h0, sq};
		end
		always_ff @(posedge clk) begin
			if (!resetn) begin
				acc_r <= 36'h000000000;
				i2_r  <= 32'h00000000;
			end else if (ce && harm.valid) begin
				acc_r <= harm.last ? 36'h000000000 : acc_nxt;
				if (harm.last)
					i2_r <= sat32(acc_nxt);
			end
		end
		assign ph_i2[p] = i2_r;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			frame_r <= 1'b0;
			i2max_r <= 32'h00000000;
		end else if (ce) begin
			frame_r <= harm.valid && harm.last;
			if (frame_r) begin
				if (ph_i2[0] >= ph_i2[1] && ph_i2[0] >= ph_i2[2])
					i2max_r <= ph_i2[0];
				else if (ph_i2[1] >= ph_i2[2])
					i2max_r <= ph_i2[1];
				else
					i2max_r <= ph_i2[2];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tick_cnt_r <= 32'h00000000;
			tick_r     <= 1'b0;
		end else if (ce) begin
			tick_r     <= tick_cnt_r == 32'(UPDATE_CYCLES - 1);
			tick_cnt_r <= (tick_cnt_r == 32'(UPDATE_CYCLES - 1)) ? 32'h00000000 : tick_cnt_r + 32'h00000001;
		end
	end

	// ambient interpolation.
	// Linear through the two limits, extrapolated outside them and floored at zero.
	always_comb begin
		int lin;
		lin = int'(lim40_r) * (AMB_HOT - AMB_REF)
			+ (int'(lim70_r) - int'(lim40_r)) * (int'($signed(amb_r)) - AMB_REF);
		if (lin < 0)
			lin = 0;
		kt_nxt = 16'(lin * Q12_ONE / ((AMB_HOT - AMB_REF) * PCT));
		if (!sensor_r || int'(lim40_r) == PCT || int'($signed(amb_r)) == AMB_REF)
			kt_nxt = KT_ONE;
	end

	// trip level.
	// The trip level and the alarm thresholds are registered to keep long products off the model path.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			kt_r     <= KT_ONE;
			trip_current_level_r   <= 16'h1000;
			imax2_r  <= 32'h01000000;
			// Thresholds start at the reset alarm setting so no false start follows reset.
			al_th_r  <= 36'(64'(AL_RST) * 64'(THETA_ONE) / 64'(PCT));
			al_rel_r <= 36'(64'(AL_RST) * 64'(THETA_ONE) * 64'(REL_PCT) / 64'(PCT * PCT));
		end else if (ce) begin
			kt_r     <= kt_nxt;
			trip_current_level_r   <= 16'(int'(sf_r) * int'(kt_r) / SF_SCALE);
			imax2_r  <= 32'(trip_current_level_r) * 32'(trip_current_level_r);
			al_th_r  <= 36'(64'(alarm_r) * 64'(THETA_ONE) / 64'(PCT));
			al_rel_r <= 36'(64'(alarm_r) * 64'(THETA_ONE) * 64'(REL_PCT) / 64'(PCT * PCT));
		end
	end

	// Shared restoring divider: one quotient bit per cycle, 64 cycles per division.
	assign rem_sh = {div_rem_r, div_num_r[63]};
	assign qbit   = rem_sh >= {1'b0, div_den_r};
	assign q_full = {div_num_r[62:0], qbit};

	assign cool_w = i2max_r < COOL_I2;
	assign n_w    = cool_w ? 32'(int'(tau_r) * int'(cool_r) * STEPS_PER_MIN / COOL_SCALE)
	                       : 32'(int'(tau_r) * STEPS_PER_MIN);
	assign target_nxt = (|q_full[63:36]) ? 36'hfffffffff : q_full[35:0];
	assign mag        = (target_nxt >= theta_r) ? target_nxt - theta_r : theta_r - target_nxt;
	assign trial      = root_r | 18'(18'h00001 << idx_r);

	// exponential heating.
	// Target is I squared over the trip level squared; each step closes 1/N of the gap.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r   <= ST_IDLE;
			div_cnt_r <= 6'h00;
			div_num_r <= 64'h0000000000000000;
			div_den_r <= 32'h00000000;
			div_rem_r <= 32'h00000000;
			theta_r   <= THETA_INIT;
			target_r  <= 36'h000000000;
			sign_r    <= 1'b0;
			root_r    <= 18'h00000;
			idx_r     <= 5'h00;
			preload_r <= 16'h0000;
		end else if (ce) begin
			unique case (state_r)
				ST_IDLE: begin
					if (tick_r) begin
						div_num_r <= {i2max_r, 32'h00000000};
						div_den_r <= imax2_r;
						div_rem_r <= 32'h00000000;
						div_cnt_r <= 6'h00;
						state_r   <= ST_TARGET;
					end
				end
				ST_TARGET, ST_STEP: begin
					div_num_r <= q_full;
					div_rem_r <= qbit ? 32'(rem_sh - {1'b0, div_den_r}) : rem_sh[31:0];
					div_cnt_r <= div_cnt_r + 6'h01;
					if (div_cnt_r == 6'h3f && state_r == ST_TARGET) begin
						target_r  <= target_nxt;
						sign_r    <= target_nxt < theta_r;
						div_num_r <= {28'h0000000, mag};
						div_den_r <= n_w;
						div_rem_r <= 32'h00000000;
						state_r   <= ST_STEP;
					end else if (div_cnt_r == 6'h3f) begin
						theta_r <= sign_r ? theta_r - q_full[35:0] : theta_r + q_full[35:0];
						root_r  <= 18'h00000;
						idx_r   <= 5'h11;
						state_r <= ST_SQRT;
					end
				end
				ST_SQRT: begin
					if (36'(trial) * 36'(trial) <= theta_r)
						root_r <= trial;
					idx_r <= idx_r - 5'h01;
					if (idx_r == 5'h00) begin
						preload_r <= 16'(int'((36'(trial) * 36'(trial) <= theta_r) ? trial : root_r)
							* int'(sf_r) / (SF_SCALE * 16));
						state_r   <= ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			start_r <= 1'b0;
			trip_r  <= 1'b0;
		end else if (ce) begin
			if (theta_r >= al_th_r)
				start_r <= 1'b1;
			else if (theta_r <= al_rel_r)
				start_r <= 1'b0;
			if (theta_r >= THETA_ONE)
				trip_r <= 1'b1;
			else if (theta_r <= THETA_REL)
				trip_r <= 1'b0;
		end
	end

	assign rd_data     = rd_data_r;
	assign stage_start = start_r;
	assign stage_trip  = trip_r;

	property p_max_phase;
		@(posedge clk) disable iff (!resetn)
		(ce && frame_r) |=> i2max_r >= ph_i2[0] && i2max_r >= ph_i2[1] && i2max_r >= ph_i2[2]
			&& (i2max_r == ph_i2[0] || i2max_r == ph_i2[1] || i2max_r == ph_i2[2]);
	endproperty
	a_max_phase: assert property (p_max_phase) else $error("Model input is not the largest phase.");

	property p_toward;
		@(posedge clk) disable iff (!resetn)
		(ce && state_r == ST_STEP && div_cnt_r == 6'h3f)
			|=> (sign_r ? (theta_r >= target_r && theta_r <= $past(theta_r))
			            : (theta_r <= target_r && theta_r >= $past(theta_r)));
	endproperty
	a_toward: assert property (p_toward) else $error("Rise did not move toward target.");

	property p_trip_set;
		@(posedge clk) disable iff (!resetn)
		(ce && theta_r >= THETA_ONE) |=> stage_trip;
	endproperty
	a_trip_set: assert property (p_trip_set) else $error("Trip missing at full rise.");

	property p_amb_hot;
		@(posedge clk) disable iff (!resetn)
		(ce && sensor_r && int'(lim40_r) != PCT && int'($signed(amb_r)) == AMB_HOT)
			|=> kt_r == 16'(int'($past(lim70_r)) * Q12_ONE / PCT);
	endproperty
	a_amb_hot: assert property (p_amb_hot) else $error("Ambient factor wrong at hot point.");

	property p_amb_unity;
		@(posedge clk) disable iff (!resetn)
		(ce && (!sensor_r || int'(lim40_r) == PCT)) |=> kt_r == KT_ONE;
	endproperty
	a_amb_unity: assert property (p_amb_unity) else $error("Ambient factor not unity.");

	property p_cool_div;
		@(posedge clk) disable iff (!resetn)
		(ce && state_r == ST_TARGET && div_cnt_r == 6'h3f && i2max_r >= COOL_I2)
			|=> div_den_r == 32'(int'(tau_r) * STEPS_PER_MIN) ##1 state_r == ST_STEP;
	endproperty
	a_cool_div: assert property (p_cool_div) else $error("Heating divisor wrong.");

	property p_root;
		@(posedge clk) disable iff (!resetn)
		(ce && state_r == ST_SQRT && idx_r == 5'h00) |=> state_r == ST_IDLE
			&& 40'(root_r) * 40'(root_r) <= 40'(theta_r) && (40'(root_r) + 40'h1) ** 2 > 40'(theta_r);
	endproperty
	a_root: assert property (p_root) else $error("Preload root wrong.");

	property p_init;
		@(posedge clk) disable iff (!resetn)
		$rose(resetn) |-> theta_r == THETA_INIT && !stage_trip && !stage_start;
	endproperty
	a_init: assert property (p_init) else $error("Rise not seventy percent after reset.");

	property p_start_set;
		@(posedge clk) disable iff (!resetn)
		(ce && theta_r >= al_th_r) |=> stage_start;
	endproperty
	a_start_set: assert property (p_start_set) else $error("Start missing at alarm limit.");

	property p_release;
		@(posedge clk) disable iff (!resetn)
		(ce && stage_trip && theta_r > THETA_REL) |=> stage_trip;
	endproperty
	a_release: assert property (p_release) else $error("Trip released above 95 percent.");

endmodule : thermal_overload_model

// *** tb/thermal_phase_source.sv ***
// Stand-in for the phase current channels that feeds harmonic frames to the stage.
module thermal_phase_source
	import thermal_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [15:0]  amp_ph0,
	input  wire logic [15:0]  amp_ph1,
	input  wire logic [15:0]  amp_ph2,
	input  wire logic [15:0]  amp_h15,
	output harm_sample_t      harm
);
	timeunit 1ns;
	timeprecision 1ps;

	harm_sample_t frame_q [6];

	// Frames repeat while out of reset; idle fields are inverted so stale values are never reused.
	initial begin
		harm = '0;
		forever begin
			@(posedge clk);
			if (resetn) begin
				// orders one and fifteen summed, order zero and phase three dropped.
				frame_q[0] = '{1'b1, 1'b0, 2'h0, 4'h1, amp_ph0};
				frame_q[1] = '{1'b1, 1'b0, 2'h0, 4'hf, amp_h15};
				frame_q[2] = '{1'b1, 1'b0, 2'h1, 4'h1, amp_ph1};
				frame_q[3] = '{1'b1, 1'b0, 2'h3, 4'h1, 16'h7fff};
				frame_q[4] = '{1'b1, 1'b0, 2'h2, 4'h0, 16'h7fff};
				frame_q[5] = '{1'b1, 1'b1, 2'h2, 4'h1, amp_ph2};
				foreach (frame_q[i]) begin
					harm <= frame_q[i];
					@(posedge clk);
				end
				harm <= '{1'b0, 1'b0, ~frame_q[5].phase, ~frame_q[5].order, ~frame_q[5].amp};
				repeat (20) @(posedge clk);
			end
		end
	end
endmodule : thermal_phase_source

// *** tb/thermal_overload_model_tb_top.sv ***
// Self-checking bench for the thermal overload stage.
module thermal_overload_model_tb_top
	import thermal_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic         clk;
	logic         resetn;
	logic         ce;
	harm_sample_t harm;
	reg_req_t     req;
	logic [15:0]  rd_data;
	logic         stage_start;
	logic         stage_trip;
	logic [15:0]  ph0, ph1, ph2, h15;
	logic [15:0]  th, th2, pl, dfast;
	logic [15:0]  rst_tab [13];
	logic [3:0]   cl_a [8];
	logic [15:0]  cl_w [8];
	logic [15:0]  cl_e [8];
	int           failures;
	int           num_checks;

	// A short update period keeps the model steps within a brief run.
	thermal_overload_model #(.UPDATE_CYCLES(200)) dut_u (
		.clk         (clk),
		.resetn      (resetn),
		.ce          (ce),
		.harm        (harm),
		.req         (req),
		.rd_data     (rd_data),
		.stage_start (stage_start),
		.stage_trip  (stage_trip)
	);

	thermal_phase_source src_u (
		.clk     (clk),
		.resetn  (resetn),
		.amp_ph0 (ph0),
		.amp_ph1 (ph1),
		.amp_ph2 (ph2),
		.amp_h15 (h15),
		.harm    (harm)
	);

	// Free-running 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		req <= '{1'b1, 1'b0, a, v};
		@(posedge clk);
		req <= '0;
	endtask : reg_wr

	// Read data stand only in the cycle after the strobe, so they are taken just past that edge.
	task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk);
		req <= '0;
		#1;
		v = rd_data;
	endtask : reg_rd

	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	task automatic chk_rd(input string name, input logic [3:0] a, input logic [15:0] e);
		logic [15:0] v;
		reg_rd(a, v);
		chk(name, e, v);
	endtask : chk_rd

	// Status carries the busy bit while a model step runs, so the compare waits for an idle read.
	task automatic chk_status(input string name, input logic [15:0] e);
		logic [15:0] v;
		int n;
		v = 16'h0000;
		v[B_BUSY] = 1'b1;
		n = 0;
		while (v[B_BUSY] !== 1'b0 && n < 200) begin
			reg_rd(A_STATUS, v);
			n++;
		end
		chk(name, e, v);
	endtask : chk_status

	// Model outputs carry rounding, so these compare within a tolerance.
	task automatic chk_near(input string name, input int e, input logic [15:0] g, input int tol);
		num_checks++;
		if ((^g === 1'bx) || (int'(g) > e + tol) || (int'(g) + tol < e)) begin
			failures++;
			$display("[ERR] %s expected %0d seen %h", name, e, g);
		end
	endtask : chk_near

	// Checks the flags against theta until trip reaches the wanted level.
	task automatic poll(input logic want, input logic [15:0] on_lvl, input logic [15:0] off_lvl);
		logic [15:0] t, st, t2;
		int n;
		n = 0;
		st = {14'h0000, ~want, 1'b0};
		while (st[B_TRIP] !== want && n < 5000) begin
			reg_rd(A_THETA, t);
			reg_rd(A_STATUS, st);
			reg_rd(A_THETA, t2);
			n++;
			if (t === t2) begin
				if (t >= on_lvl) chk("trip set", 16'h0001, {15'h0000, st[B_TRIP]});
				if (t < off_lvl) chk("trip clear", 16'h0000, {15'h0000, st[B_TRIP]});
				if (t >= 16'h0cce) chk("start set", 16'h0001, {15'h0000, st[B_START]});
				if (t < 16'h0ccb) chk("start clear", 16'h0000, {15'h0000, st[B_START]});
			end
		end
		chk("trip reached", {15'h0000, want}, {15'h0000, st[B_TRIP]});
		chk("trip pin", {15'h0000, want}, {15'h0000, stage_trip});
		chk("start pin", 16'h0001, {15'h0000, stage_start});
	endtask : poll

	task automatic complete_run();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run

	// The whole sequence needs about 35k cycles, so 100k cycles means a hang.
	initial begin
		#2000000;
		failures++;
		$display("[ERR] watchdog expected finish seen timeout");
		complete_run();
	end

	initial begin
		rst_tab = '{16'h0064, 16'h001e, 16'h000a, 16'h0064, 16'h0064, 16'h0028, 16'h005a, 16'h0000, 16'h0b33,
			16'h0000, 16'h1000, 16'h1000, 16'h0000};
		cl_a = '{A_TAU, A_TAU, A_SERVICE, A_SERVICE, A_COOL, A_COOL, A_ALARM, A_ALARM};
		cl_w = '{16'h00ff, 16'h0001, 16'h0000, 16'h00ff, 16'h0005, 16'h00ff, 16'h003b, 16'h0064};
		cl_e = '{16'h00b4, 16'h0002, 16'h000a, 16'h00f0, 16'h000a, 16'h0064, 16'h003c, 16'h0063};
		resetn = 1'b0;
		ce = 1'b1;
		req = '0;
		ph0 = 16'h0000;
		ph1 = 16'h0000;
		ph2 = 16'h0000;
		h15 = 16'h0000;
		failures = 0;
		num_checks = 0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1;
		chk("outputs after reset", 16'h0000, {14'h0000, stage_trip, stage_start});
		// reset values, preload skipped until the first step.
		for (int i = 0; i < 13; i++) begin
			if (i != 9) chk_rd("reset value", i[3:0], rst_tab[i]);
		end
		reg_wr(A_THETA, 16'hffff);
		chk_rd("theta read-only", A_THETA, 16'h0b33);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			reg_wr(cl_a[i], cl_w[i]);
			chk_rd("clamped setting", cl_a[i], cl_e[i]);
		end
		reg_wr(A_SERVICE, 16'h0064);
		reg_wr(A_COOL, 16'h000a);
		reg_wr(A_ALARM, 16'h0050);
		reg_wr(A_TAU, 16'h0002);
		$display("test ranges done");
		reg_wr(A_LIM40, 16'h0078);
		reg_wr(A_LIM70, 16'h0032);
		reg_wr(A_AMBIENT, 16'h0146);
		repeat (3) @(posedge clk);
		chk_rd("ambient factor at 70", A_KTHETA, 16'h0800);
		chk_rd("trip level", A_TRIPLVL, 16'h0800);
		reg_wr(A_AMBIENT, 16'h0128);
		repeat (3) @(posedge clk);
		chk_rd("ambient factor at 40", A_KTHETA, 16'h1000);
		reg_wr(A_AMBIENT, 16'h0046);
		repeat (3) @(posedge clk);
		chk_rd("ambient factor no sensor", A_KTHETA, 16'h1000);
		reg_wr(A_AMBIENT, 16'h0146);
		$display("test ambient done");
		// fifteenth harmonic counted, only the largest phase used.
		ph0 <= 16'h0666;
		h15 <= 16'h04cd;
		ph1 <= 16'h0666;
		repeat (100) @(posedge clk);
		reg_rd(A_THETA, th);
		repeat (8000) @(posedge clk);
		reg_rd(A_THETA, th2);
		chk_near("theta rise over 40 steps", 40, th2 - th, 6);
		chk_status("no trip near target", 16'h0000);
		$display("test harmonics done");
		// heating to trip, then cooling to release.
		ph0 <= 16'h2000;
		h15 <= 16'h0000;
		ph1 <= 16'h0000;
		poll(1'b1, 16'h1001, 16'h0fff);
		ph0 <= 16'h0000;
		poll(1'b0, 16'h0f35, 16'h0f32);
		$display("test trip done");
		// preload follows the root of theta.
		reg_rd(A_THETA, th);
		reg_rd(A_PRELOAD, pl);
		chk_near("preload", $rtoi(64.0 * $sqrt(real'(th))), pl, 8);
		// cooling coefficient slows the decay tenfold.
		repeat (4000) @(posedge clk);
		reg_rd(A_THETA, th2);
		dfast = th - th2;
		reg_wr(A_COOL, 16'h0064);
		reg_rd(A_THETA, th);
		repeat (4000) @(posedge clk);
		reg_rd(A_THETA, th2);
		chk("slow cooling", 16'h0001, {15'h0000, (dfast > 16'h0014) && (dfast > 5 * (th - th2))});
		$display("test cooling done");
		complete_run();
	end
endmodule : thermal_overload_model_tb_top
